// file: ctt_core.sv
`timescale 1ns/10ps
`include "ctt_defs.svh"
module ctt_core (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    // Memory bus
    output ctt_pkg::ctt_mem_t      mem_out,
    input  wire logic [7:0]        mem_rdata_in,
    // Wake-up
    input  wire logic              irq_in,
    // Status
    output logic [7:0]             acc_out,
    output logic [15:0]            index_out,
    output logic [15:0]            stack_out,
    output ctt_pkg::ctt_flag_t     flags_out,
    output logic                   waiting_out
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    ctt_pkg::ctt_state_t state;
    ctt_pkg::ctt_state_t next_state;
    ctt_pkg::ctt_dec_t   dec;
    ctt_pkg::ctt_dec_t   fdec;
    ctt_pkg::ctt_flag_t  flags;
    logic [15:0]         pc;
    logic [15:0]         hx;
    logic [15:0]         stk;
    logic [7:0]          acc;
    logic [7:0]          op_q;
    logic [7:0]          b1;
    logic [7:0]          b2;
    logic [7:0]          tmp;
    logic [2:0]          cnt;
    logic                pre;
    logic                idx;
    logic                irq_m;
    logic                irq_s;
    logic [15:0]         rd_ea;
    logic [15:0]         wr_ea;
    logic [7:0]          rel;
    logic                take;
    logic                fin;
    logic                is_pre;
    logic                last_opnd;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic ctt_pkg::ctt_dec_t decode(input logic p, input logic [7:0] op);
        ctt_pkg::ctt_dec_t d;
        d = '{kind: ctt_pkg::K_NOP, mode: ctt_pkg::M_INH, nops: 2'd0, cyc: 3'd1};
        if (p) begin
            if (op == `CTT_OP_TZ_XO8) d = '{ctt_pkg::K_TSTM, ctt_pkg::M_SO8, 2'd1, 3'd4};
            if (op == `CTT_OP_LDA_XO16) d = '{ctt_pkg::K_LDA, ctt_pkg::M_SO16, 2'd2, 3'd5};
        end else if (op[7:4] == 4'h0) begin
            d = '{ctt_pkg::K_BRBIT, ctt_pkg::M_DIR, 2'd2, 3'd5};
        end else begin
            unique case (op)
                `CTT_OP_TZ_DIR:   d = '{ctt_pkg::K_TSTM, ctt_pkg::M_DIR, 2'd1, 3'd3};
                `CTT_OP_TZ_A:     d = '{ctt_pkg::K_TSTA, ctt_pkg::M_INH, 2'd0, 3'd1};
                `CTT_OP_TZ_X:     d = '{ctt_pkg::K_TSTX, ctt_pkg::M_INH, 2'd0, 3'd1};
                `CTT_OP_TZ_XO8:   d = '{ctt_pkg::K_TSTM, ctt_pkg::M_XO8, 2'd1, 3'd3};
                `CTT_OP_TZ_XI:    d = '{ctt_pkg::K_TSTM, ctt_pkg::M_IX, 2'd0, 3'd2};
                `CTT_OP_S2X:      d = '{ctt_pkg::K_S2X, ctt_pkg::M_INH, 2'd0, 3'd2};
                `CTT_OP_X2S:      d = '{ctt_pkg::K_X2S, ctt_pkg::M_INH, 2'd0, 3'd2};
                `CTT_OP_X2A:      d = '{ctt_pkg::K_X2A, ctt_pkg::M_INH, 2'd0, 3'd1};
                `CTT_OP_WAIT:     d = '{ctt_pkg::K_WAIT, ctt_pkg::M_INH, 2'd0, 3'd1};
                `CTT_OP_CBEQ_DIR: d = '{ctt_pkg::K_CBEQ, ctt_pkg::M_DIR, 2'd2, 3'd5};
                `CTT_OP_CBEQ_XO8: d = '{ctt_pkg::K_CBEQ, ctt_pkg::M_IX1P, 2'd2, 3'd5};
                `CTT_OP_CBEQ_IX:  d = '{ctt_pkg::K_CBEQ, ctt_pkg::M_IXP, 2'd1, 3'd4};
                `CTT_OP_MOV_D2D:  d = '{ctt_pkg::K_MOV, ctt_pkg::M_D2D, 2'd2, 3'd5};
                `CTT_OP_MOV_DIX:  d = '{ctt_pkg::K_MOV, ctt_pkg::M_DIXP, 2'd1, 3'd4};
                `CTT_OP_MOV_I2D:  d = '{ctt_pkg::K_MOV, ctt_pkg::M_I2D, 2'd2, 3'd4};
                `CTT_OP_MOV_IXD:  d = '{ctt_pkg::K_MOV, ctt_pkg::M_IXPD, 2'd1, 3'd4};
                `CTT_OP_LDA_ABS:  d = '{ctt_pkg::K_LDA, ctt_pkg::M_ABS, 2'd2, 3'd4};
                `CTT_OP_LDA_XO16: d = '{ctt_pkg::K_LDA, ctt_pkg::M_XO16, 2'd2, 3'd4};
                `CTT_OP_LDA_XO8:  d = '{ctt_pkg::K_LDA, ctt_pkg::M_XO8, 2'd1, 3'd3};
                default:          d = d;
            endcase
        end
        return d;
    endfunction : decode

    // ----------------------------------------
    // Address and control helpers
    // ----------------------------------------
    assign fdec      = decode(pre, mem_rdata_in);
    assign is_pre    = (state == ctt_pkg::ST_FETCH) && !pre && (mem_rdata_in == `CTT_OP_PRE);
    assign last_opnd = ({1'b0, idx} == dec.nops - 2'd1);
    assign rel       = (dec.mode == ctt_pkg::M_IXP) ? b1 : b2;
    assign take      = (dec.kind == ctt_pkg::K_CBEQ) ? (acc == mem_rdata_in)
                                                     : (mem_rdata_in[op_q[3:1]] ^ op_q[0]);
    assign fin       = ({1'b0, cnt} + 4'd1) >= {1'b0, (state == ctt_pkg::ST_FETCH) ? fdec.cyc : dec.cyc};

    always_comb begin
        unique case (dec.mode)
            ctt_pkg::M_ABS:                   rd_ea = {b1, b2};
            ctt_pkg::M_IX, ctt_pkg::M_IXP,
            ctt_pkg::M_IXPD:                  rd_ea = hx;
            ctt_pkg::M_XO8, ctt_pkg::M_IX1P:  rd_ea = hx + {8'h00, b1};
            ctt_pkg::M_XO16:                  rd_ea = hx + {b1, b2};
            ctt_pkg::M_SO8:                   rd_ea = stk + {8'h00, b1};
            ctt_pkg::M_SO16:                  rd_ea = stk + {b1, b2};
            default:                          rd_ea = {8'h00, b1};
        endcase
        unique case (dec.mode)
            ctt_pkg::M_DIXP:                  wr_ea = hx;
            ctt_pkg::M_IXPD:                  wr_ea = {8'h00, b1};
            default:                          wr_ea = {8'h00, b2};
        endcase
    end

    always_comb begin
        mem_out.addr  = pc;
        mem_out.rd    = 1'b0;
        mem_out.we    = 1'b0;
        mem_out.wdata = (dec.mode == ctt_pkg::M_I2D) ? b1 : tmp;
        unique case (state)
            ctt_pkg::ST_FETCH, ctt_pkg::ST_OPND: mem_out.rd = 1'b1;
            ctt_pkg::ST_READ: begin
                mem_out.addr = rd_ea;
                mem_out.rd   = 1'b1;
            end
            ctt_pkg::ST_WRITE: begin
                mem_out.addr = wr_ea;
                mem_out.we   = 1'b1;
            end
            default: mem_out.rd = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ctt_pkg::ST_FETCH: begin
                if (is_pre)
                    next_state = ctt_pkg::ST_FETCH;
                else if (fdec.nops != 2'd0)
                    next_state = ctt_pkg::ST_OPND;
                else if (fdec.mode != ctt_pkg::M_INH)
                    next_state = ctt_pkg::ST_READ;
                else if (fdec.kind == ctt_pkg::K_WAIT)
                    next_state = ctt_pkg::ST_WAIT;
                else
                    next_state = fin ? ctt_pkg::ST_FETCH : ctt_pkg::ST_PAD;
            end
            ctt_pkg::ST_OPND: begin
                if (last_opnd)
                    next_state = (dec.mode == ctt_pkg::M_I2D) ? ctt_pkg::ST_WRITE : ctt_pkg::ST_READ;
            end
            ctt_pkg::ST_READ: begin
                if (dec.kind == ctt_pkg::K_MOV)
                    next_state = ctt_pkg::ST_WRITE;
                else
                    next_state = fin ? ctt_pkg::ST_FETCH : ctt_pkg::ST_PAD;
            end
            ctt_pkg::ST_WRITE, ctt_pkg::ST_PAD:
                next_state = fin ? ctt_pkg::ST_FETCH : ctt_pkg::ST_PAD;
            ctt_pkg::ST_WAIT:
                next_state = irq_s ? ctt_pkg::ST_FETCH : ctt_pkg::ST_WAIT;
            default: next_state = ctt_pkg::ST_FETCH;
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ctt_pkg::ST_FETCH;
            dec   <= '0;
            op_q  <= 8'h00;
            b1    <= 8'h00;
            b2    <= 8'h00;
            tmp   <= 8'h00;
            cnt   <= 3'h0;
            pre   <= 1'b0;
            idx   <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= (next_state == ctt_pkg::ST_FETCH && !is_pre) ? 3'h0 : cnt + 3'h1;
            if (state == ctt_pkg::ST_FETCH) begin
                pre <= is_pre;
                idx <= 1'b0;
                if (!is_pre) begin
                    dec  <= fdec;
                    op_q <= mem_rdata_in;
                end
            end
            if (state == ctt_pkg::ST_OPND) begin
                idx <= 1'b1;
                if (idx)
                    b2 <= mem_rdata_in;
                else
                    b1 <= mem_rdata_in;
            end
            if (state == ctt_pkg::ST_READ)
                tmp <= mem_rdata_in;
        end
    end

    // Wake-up pin synchroniser
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_m <= 1'b0;
            irq_s <= 1'b0;
        end else begin
            irq_m <= irq_in;
            irq_s <= irq_m;
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in)
            pc <= `CTT_PC_RST;
        else if (state == ctt_pkg::ST_FETCH || state == ctt_pkg::ST_OPND)
            pc <= pc + 16'h0001;
        else if (state == ctt_pkg::ST_READ && take &&
                 (dec.kind == ctt_pkg::K_CBEQ || dec.kind == ctt_pkg::K_BRBIT))
            pc <= pc + {{8{rel[7]}}, rel};
    end

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc <= 8'h00;
            hx  <= 16'h0000;
            stk <= `CTT_STK_RST;
        end else begin
            if (state == ctt_pkg::ST_FETCH && !is_pre) begin
                unique case (fdec.kind)
                    ctt_pkg::K_S2X: hx  <= stk + 16'h0001;
                    ctt_pkg::K_X2S: stk <= hx - 16'h0001;
                    ctt_pkg::K_X2A: acc <= hx[7:0];
                    default: acc <= acc;
                endcase
            end
            if (state == ctt_pkg::ST_READ) begin
                if (dec.kind == ctt_pkg::K_LDA)
                    acc <= mem_rdata_in;
                if (dec.mode == ctt_pkg::M_IXP || dec.mode == ctt_pkg::M_IX1P || dec.mode == ctt_pkg::M_IXPD)
                    hx <= hx + 16'h0001;
            end
            if (state == ctt_pkg::ST_WRITE && dec.mode == ctt_pkg::M_DIXP)
                hx <= hx + 16'h0001;
        end
    end

    // ----------------------------------------
    // Condition codes
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags <= `CTT_FLAGS_RST;
        end else if (state == ctt_pkg::ST_FETCH && !is_pre) begin
            if (fdec.kind == ctt_pkg::K_TSTA || fdec.kind == ctt_pkg::K_TSTX) begin
                flags.v <= 1'b0;
                flags.n <= (fdec.kind == ctt_pkg::K_TSTA) ? acc[7] : hx[7];
                flags.z <= (fdec.kind == ctt_pkg::K_TSTA) ? (acc == 8'h00) : (hx[7:0] == 8'h00);
            end
            if (fdec.kind == ctt_pkg::K_WAIT)
                flags.i <= 1'b0;
        end else if (state == ctt_pkg::ST_READ) begin
            if (dec.kind == ctt_pkg::K_TSTM || dec.kind == ctt_pkg::K_LDA) begin
                flags.v <= 1'b0;
                flags.n <= mem_rdata_in[7];
                flags.z <= (mem_rdata_in == 8'h00);
            end
            if (dec.kind == ctt_pkg::K_BRBIT)
                flags.c <= mem_rdata_in[op_q[3:1]];
        end
    end

    assign acc_out     = acc;
    assign index_out   = hx;
    assign stack_out   = stk;
    assign flags_out   = flags;
    assign waiting_out = (state == ctt_pkg::ST_WAIT);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    logic new_op;
    assign new_op = state == ctt_pkg::ST_FETCH && !pre && !is_pre;

    property p_tza_len;
        new_op && mem_rdata_in == `CTT_OP_TZ_A |=> state == ctt_pkg::ST_FETCH;
    endproperty
    a_tza_len: assert property (p_tza_len) else $error("accumulator test not one cycle");
    property p_tz_dir_len;
        new_op && mem_rdata_in == `CTT_OP_TZ_DIR |=> state != ctt_pkg::ST_FETCH ##1
            state != ctt_pkg::ST_FETCH ##1 state == ctt_pkg::ST_FETCH;
    endproperty
    a_tz_dir_len: assert property (p_tz_dir_len) else $error("direct test not three cycles");
    property p_tz_flags;
        new_op && mem_rdata_in == `CTT_OP_TZ_A |=>
            !flags.v && flags.z == ($past(acc) == 8'h00) && flags.c == $past(flags.c) && acc == $past(acc);
    endproperty
    a_tz_flags: assert property (p_tz_flags) else $error("test flags wrong");
    property p_s2x;
        new_op && mem_rdata_in == `CTT_OP_S2X |=> hx == $past(stk) + 16'h0001 && flags == $past(flags)
            ##1 state == ctt_pkg::ST_FETCH;
    endproperty
    a_s2x: assert property (p_s2x) else $error("stack to index wrong");
    property p_x2s;
        new_op && mem_rdata_in == `CTT_OP_X2S |=> stk == $past(hx) - 16'h0001 && state == ctt_pkg::ST_PAD;
    endproperty
    a_x2s: assert property (p_x2s) else $error("index to stack wrong");
    property p_wait;
        new_op && mem_rdata_in == `CTT_OP_WAIT |=> !flags.i && waiting_out && !mem_out.rd;
    endproperty
    a_wait: assert property (p_wait) else $error("wait did not halt");
    property p_postinc;
        state == ctt_pkg::ST_READ && dec.mode == ctt_pkg::M_IXP |->
            mem_out.addr == hx ##1 hx == $past(hx) + 16'h0001;
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong");
    property p_abs;
        state == ctt_pkg::ST_READ && dec.mode == ctt_pkg::M_ABS |-> mem_out.addr == {b1, b2};
    endproperty
    a_abs: assert property (p_abs) else $error("extended address wrong");
    property p_so16;
        state == ctt_pkg::ST_READ && dec.mode == ctt_pkg::M_SO16 |-> mem_out.addr == stk + {b1, b2};
    endproperty
    a_so16: assert property (p_so16) else $error("stack offset address wrong");
    property p_d2d;
        state == ctt_pkg::ST_READ && dec.mode == ctt_pkg::M_D2D |=>
            mem_out.we && mem_out.addr == {8'h00, b2} && mem_out.wdata == $past(mem_rdata_in);
    endproperty
    a_d2d: assert property (p_d2d) else $error("direct move wrong");

    c_wait_wake: cover property (waiting_out ##1 state == ctt_pkg::ST_FETCH);
    c_branch: cover property (state == ctt_pkg::ST_READ && take && dec.kind == ctt_pkg::K_CBEQ);
    c_mov_i2d: cover property (state == ctt_pkg::ST_WRITE && dec.mode == ctt_pkg::M_I2D);
endmodule : ctt_core

// file: ctt_defs.svh
`ifndef CTT_DEFS_SVH
`define CTT_DEFS_SVH

// Opcodes
`define CTT_OP_PRE      8'h9E
`define CTT_OP_TZ_DIR   8'h3D
`define CTT_OP_TZ_A     8'h4D
`define CTT_OP_TZ_X     8'h5D
`define CTT_OP_TZ_XO8   8'h6D
`define CTT_OP_TZ_XI    8'h7D
`define CTT_OP_S2X      8'h95
`define CTT_OP_X2S      8'h94
`define CTT_OP_X2A      8'h9F
`define CTT_OP_WAIT     8'h8F
`define CTT_OP_CBEQ_DIR 8'h31
`define CTT_OP_CBEQ_XO8 8'h61
`define CTT_OP_CBEQ_IX  8'h71
`define CTT_OP_MOV_D2D  8'h4E
`define CTT_OP_MOV_DIX  8'h5E
`define CTT_OP_MOV_I2D  8'h6E
`define CTT_OP_MOV_IXD  8'h7E
`define CTT_OP_LDA_ABS  8'hC6
`define CTT_OP_LDA_XO16 8'hD6
`define CTT_OP_LDA_XO8  8'hE6

// Reset values
`define CTT_PC_RST      16'h0000
`define CTT_STK_RST     16'h00FF
`define CTT_FLAGS_RST   8'h68
`endif

// file: ctt_pkg.sv
package ctt_pkg;
    typedef enum logic [5:0] {
        ST_FETCH = 6'h01,
        ST_OPND  = 6'h02,
        ST_READ  = 6'h04,
        ST_WRITE = 6'h08,
        ST_PAD   = 6'h10,
        ST_WAIT  = 6'h20
    } ctt_state_t;

    typedef enum logic [3:0] {
        M_INH, M_DIR, M_ABS, M_IX, M_XO8, M_XO16, M_SO8, M_SO16,
        M_IXP, M_IX1P, M_D2D, M_DIXP, M_I2D, M_IXPD
    } ctt_mode_t;

    typedef enum logic [3:0] {
        K_NOP, K_TSTA, K_TSTX, K_TSTM, K_S2X, K_X2S, K_X2A,
        K_WAIT, K_MOV, K_CBEQ, K_BRBIT, K_LDA
    } ctt_kind_t;

    typedef struct packed {
        ctt_kind_t  kind;
        ctt_mode_t  mode;
        logic [1:0] nops;
        logic [2:0] cyc;
    } ctt_dec_t;

    typedef struct packed {
        logic       v;
        logic [1:0] one;
        logic       h;
        logic       i;
        logic       n;
        logic       z;
        logic       c;
    } ctt_flag_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        we;
    } ctt_mem_t;
endpackage : ctt_pkg

// file: ctt_core_tb.sv
`timescale 1ns/10ps
module ctt_core_tb;
    // ------
    // Signals
    // ------
    logic              mclk_in = 1'b0;
    logic              nrst_in = 1'b0;
    logic              irq_in  = 1'b0;
    ctt_pkg::ctt_mem_t mbus;
    ctt_pkg::ctt_flag_t flags_out;
    logic [7:0]        mem_rdata_in, acc_out, eccr, acc_e, d;
    logic [15:0]       index_out, stack_out, pc;
    logic [15:0]       lfsr = 16'h0010;
    logic              waiting_out;
    logic [7:0]        mem [0:65535];
    int                err_count = 0;
    int                checks = 0;

    ctt_core uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .mem_out(mbus), .mem_rdata_in(mem_rdata_in),
                  .irq_in(irq_in), .acc_out(acc_out), .index_out(index_out), .stack_out(stack_out),
                  .flags_out(flags_out), .waiting_out(waiting_out));

    // ------
    // Clock and memory
    // ------
    always #25 mclk_in = ~mclk_in;
    assign mem_rdata_in = mem[mbus.addr];
    always @(posedge mclk_in) begin
        if (mbus.we)
            mem[mbus.addr] <= mbus.wdata;
    end

    // ------
    // Helpers
    // ------
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    function automatic logic [7:0] nz(input logic [7:0] c, input logic [7:0] v);
        return {1'b0, c[6:3], v[7], v == 8'h00, c[0]};
    endfunction : nz

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // Place bytes at pc, see the fetch, run the given cycle count
    task automatic exec(input logic [31:0] ib, input int len, input int cyc);
        for (int k = 0; k < len; k++)
            mem[pc + 16'(k)] = ib[31 - 8 * k -: 8];
        chk(mbus.addr, pc);
        chk(mbus.rd, 1'b1);
        repeat (cyc) @(posedge mclk_in);
        #1;
        pc = pc + 16'(len);
    endtask : exec

    // Operand at ea, its complement at the misformed address
    task automatic probe(input logic [15:0] ea, bad, input logic [7:0] v, input logic [31:0] ib,
                         input int len, cyc, input logic lda);
        mem[ea] = v;
        mem[bad] = ~v;
        exec(ib, len, cyc);
        if (lda)
            acc_e = v;
        chk(acc_out, acc_e);
        eccr = nz(eccr, v);
        chk(flags_out, eccr);
        chk(mem[ea], v);
    endtask : probe

    initial begin
        repeat (5000) @(posedge mclk_in);
        err_count++;
        give_verdict();
    end

    // ------
    // Main sequence
    // ------
    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'h00;
        acc_e = 8'h00;
        repeat (16) @(posedge mclk_in);
        nrst_in <= 1'b1;
        #1;
        pc = 16'h0000;
        eccr = 8'h68;
        exec(32'h95000000, 1, 2);
        chk(index_out, 16'h0100);
        chk(flags_out, eccr);
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : rnd();
            probe(16'h00C0, 16'h00C1, d, 32'h3DC00000, 2, 3, 1'b0);
        end
        probe(16'h4000, 16'h0040, rnd(), 32'hC6400000, 3, 4, 1'b1);
        probe(16'h1334, 16'h3512, rnd(), 32'hD6123400, 3, 4, 1'b1);
        probe(16'h20FF, 16'h011F, rnd(), 32'h9ED62000, 4, 5, 1'b1);
        probe(16'h01F0, 16'h00F0, rnd() | 8'h01, 32'hE6F00000, 2, 3, 1'b1);
        exec(32'h4D000000, 1, 1);
        eccr = nz(eccr, acc_e);
        chk(flags_out, eccr);
        exec(32'h5D000000, 1, 1);
        eccr = nz(eccr, 8'h00);
        chk(flags_out, eccr);
        probe(16'h01F0, 16'h00F0, rnd(), 32'h6DF00000, 2, 3, 1'b0);
        probe(16'h0100, 16'h0101, rnd(), 32'h7D000000, 1, 2, 1'b0);
        probe(16'h01EF, 16'h00EF, rnd(), 32'h9E6DF000, 3, 4, 1'b0);
        d = rnd();
        exec({8'h6E, d, 16'hC800}, 3, 4);
        chk(mem[16'h00C8], d);
        mem[16'h00C9] = rnd();
        exec(32'h4EC9CA00, 3, 5);
        chk(mem[16'h00CA], mem[16'h00C9]);
        mem[16'h00CB] = rnd();
        exec(32'h5ECB0000, 2, 4);
        chk(mem[16'h0100], mem[16'h00CB]);
        chk(index_out, 16'h0101);
        mem[16'h0101] = rnd();
        exec(32'h7ECC0000, 2, 4);
        chk(mem[16'h00CC], mem[16'h0101]);
        chk(index_out, 16'h0102);
        exec(32'h9F000000, 1, 1);
        chk(acc_out, 8'h02);
        acc_e = 8'h02;
        exec(32'h94000000, 1, 2);
        chk(stack_out, 16'h0101);
        chk(flags_out, eccr);
        exec(32'h8F000000, 1, 1);
        eccr[3] = 1'b0;
        chk(flags_out, eccr);
        repeat (4) @(posedge mclk_in);
        #1;
        chk(waiting_out, 1'b1);
        chk(mbus.rd, 1'b0);
        mem[pc] = 8'h9D;
        @(posedge mclk_in);
        irq_in <= 1'b1;
        for (int n = 0; n < 8 && waiting_out !== 1'b0; n++) begin
            @(posedge mclk_in);
            #1;
        end
        chk(waiting_out, 1'b0);
        chk(mbus.addr, pc);
        @(posedge mclk_in);
        irq_in <= 1'b0;
        #1;
        pc = pc + 16'h0001;
        mem[16'h0102] = acc_e;
        exec(32'h71040000, 2, 4);
        pc = pc + 16'h0004;
        chk(index_out, 16'h0103);
        mem[16'h0113] = ~acc_e;
        exec(32'h61100400, 3, 5);
        chk(index_out, 16'h0104);
        mem[16'h00CD] = acc_e;
        exec(32'h31CDFE00, 3, 5);
        pc = pc - 16'h0002;
        mem[16'h00CE] = 8'h01;
        exec(32'h00CE0500, 3, 5);
        pc = pc + 16'h0005;
        chk(flags_out.c, 1'b1);
        exec(32'h9D000000, 1, 1);
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        #1;
        chk(stack_out, 16'h00FF);
        chk(flags_out, 8'h68);
        chk(mbus.addr, 16'h0000);
        @(posedge mclk_in);
        nrst_in <= 1'b1;
        #1;
        pc = 16'h0000;
        eccr = 8'h68;
        exec(32'h95000000, 1, 2);
        chk(index_out, 16'h0100);
        give_verdict();
    end
endmodule : ctt_core_tb
